// ---- logic/amc_pkg.sv ----
// amc_pkg: register map, field layouts, mode codes and timing constants
// for the mode, master clock and pin control register bank.
// assumes a 100 MHz ref_clk and a host on the four-wire serial port.
package amc_pkg;

  // --------------------------------------------------------------------
  // register addresses and serial framing
  // --------------------------------------------------------------------
  localparam logic [5:0] ADDR_CONV_CTRL = 6'h01;
  localparam logic [5:0] ADDR_RESULT = 6'h02;
  localparam logic [5:0] ADDR_IO_CTRL = 6'h03;
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam int CMD_READ_BIT = 6;
  localparam logic [5:0] LEN_RESULT = 6'h18;
  localparam logic [5:0] LEN_CTRL = 6'h10;
  localparam logic [5:0] LEN_OTHER = 6'h08;

  // --------------------------------------------------------------------
  // field layouts and reset values
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [8:0] rsvd;
    logic duty_ratio_field;
    logic [3:0] mode;
    logic [1:0] mclk_sel;
  } amc_conv_ctrl_type;

  typedef struct packed {
    logic [4:0] rsvd;
    logic trigger_fifo_clear_enable;
    logic [1:0] int_route;
    logic [3:0] gp_out_level;
    logic [3:0] gp_dir;
  } amc_io_ctrl_type;

  localparam logic [15:0] CONV_CTRL_RST = 16'h0000;
  localparam logic [15:0] CONV_CTRL_WMASK = 16'h007F;
  localparam logic [15:0] IO_CTRL_RST = 16'h0000;
  localparam logic [15:0] IO_CTRL_WMASK = 16'h07FF;
  localparam logic [23:0] RESULT_RST = 24'h000000;

  // --------------------------------------------------------------------
  // mode, clock source and interrupt routing codes
  // --------------------------------------------------------------------
  localparam logic [3:0] MODE_DUTY = 4'h9;
  localparam logic [3:0] MODE_SEQ_IDLE = 4'hA;
  localparam logic [3:0] MODE_SEQ_STBY = 4'hB;
  localparam logic [1:0] MCLK_INT_OFF = 2'h0;
  localparam logic [1:0] MCLK_INT_ON = 2'h1;
  localparam logic [1:0] MCLK_EXT = 2'h2;
  localparam logic [1:0] MCLK_EXT_DIV2 = 2'h3;
  localparam logic [1:0] ROUTE_INT = 2'h0;
  localparam logic [1:0] ROUTE_CLK = 2'h1;
  localparam logic [1:0] ROUTE_GP2 = 2'h2;
  localparam logic [1:0] ROUTE_DOUT = 2'h3;
  localparam int DUTY_SHIFT_QUARTER = 2;
  localparam int DUTY_SHIFT_SIXTEENTH = 4;
  localparam int GP_TWO = 1;
  localparam int GP_FOUR = 3;

  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int INT_OSC_HZ = 76_800;
  localparam int OSC_HALF_CYC = CLK_HZ / (2 * INT_OSC_HZ);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_REST = 2'b11,
    ST_WAIT = 2'b10
  } amc_seq_type;

endpackage : amc_pkg

// ---- logic/amc_regs.sv ----
// amc_regs: serial-port register bank with sequencer modes, master clock
// selection, latest result register and pin routing.
// assumes all pins are synchronous to ref_clk; the converter core
// reports each result on conv_done and the sequence end on conv_last.
`timescale 1ns/1ps

// Notes on behaviour
// - mode 1001 alternates sequence and standby by ratio
// - mode 1010 one sequence, idle, trigger restarts
// - mode 1011 one sequence, standby, trigger restarts
// - clock 00/01 internal oscillator, 01 drives pin
// - clock 10 takes pin directly as master
// - clock 11 halves the pin clock
// - result register read-only, 24 bits, latest
// - trigger clears fifo only when enabled
// - data ready is event unless fifo enabled
// - route 00 event to int pin, or ready to dout pin on lfcsp
// - route 01 event onto clock pin, overriding
// - route 10 event onto pin two, overriding
// - route 11 ready on dout, fifo unrouted
// - output level bits drive output pins
// - standby indicator owns pin four first
// - control bit 0 input, 1 output
module amc_regs import amc_pkg::*; #(
  parameter int OSC_HALF = OSC_HALF_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial port
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // converter core
  input wire logic conv_done,
  input wire logic conv_last,
  input wire logic [23:0] conv_data,
  output logic seq_start,
  output logic seq_active,
  output logic standby_active,
  output logic idle_active,
  output logic mclk_tick,
  // fifo and trigger
  input wire logic fifo_enable,
  input wire logic fifo_irq,
  output logic fifo_clear,
  input wire logic trig_n,
  // package and misc
  input wire logic pkg_lfcsp,
  input wire logic standby_indicator_enable,
  // pins
  output logic int_pin_o,
  output logic int_pin_oe,
  input wire logic clk_pin_i,
  output logic clk_pin_o,
  output logic clk_pin_oe,
  output logic [3:0] gp_pin_o,
  output logic [3:0] gp_pin_oe
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [5:0] frame_len(input logic [5:0] a);
    if (a == ADDR_RESULT) begin
      return LEN_RESULT;
    end
    if (a == ADDR_CONV_CTRL || a == ADDR_IO_CTRL) begin
      return LEN_CTRL;
    end
    return LEN_OTHER;
  endfunction : frame_len

  function automatic logic is_seq_mode(input logic [3:0] m);
    return m == MODE_DUTY || m == MODE_SEQ_IDLE || m == MODE_SEQ_STBY;
  endfunction : is_seq_mode

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  amc_conv_ctrl_type conv_ctrl_r;
  amc_io_ctrl_type io_ctrl_r;
  logic [23:0] result_r;
  logic drdy_n_r;
  logic sclk_d_r;
  logic [5:0] bit_cnt_r;
  logic [7:0] cmd_r;
  logic [23:0] shift_r;
  logic [23:0] out_r;
  logic mode_wr_r;
  logic [9:0] osc_cnt_r;
  logic osc_r;
  logic clk_d_r;
  logic div2_r;
  logic mclk_tick_r;
  logic trig_d_r;
  logic fifo_clear_r;
  amc_seq_type state_r;
  logic seq_start_r;
  logic [15:0] conv_len_r;
  logic [19:0] rest_cnt_r;

  logic spi_rise, spi_fall, in_data, frame_last, cmd_read, rdy_on_dout;
  logic seq_end, trig_fall, osc_half, ext_rise, int_event, pin_event;
  logic [7:0] cmd_nxt;
  logic [23:0] wdata;
  logic [19:0] rest_len;

  default clocking chk_cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------------
  // serial port framing
  // ----------------------------------------------------------------------
  assign spi_rise = spi_sclk & ~sclk_d_r & ~spi_cs_n;
  assign spi_fall = ~spi_sclk & sclk_d_r & ~spi_cs_n;
  assign in_data = bit_cnt_r >= CMD_BITS;
  assign cmd_read = cmd_r[CMD_READ_BIT];
  assign cmd_nxt = {cmd_r[6:0], spi_sdi};
  assign wdata = {shift_r[22:0], spi_sdi};
  assign frame_last = spi_rise && in_data &&
    bit_cnt_r == CMD_BITS + frame_len(cmd_r[5:0]) - 6'h01;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_d_r <= 1'b1;
    end else begin
      sclk_d_r <= spi_sclk;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bit_cnt_r <= 6'h00;
      cmd_r <= 8'h00;
      shift_r <= 24'h000000;
    end else if (spi_cs_n) begin
      bit_cnt_r <= 6'h00;
    end else if (spi_rise) begin
      bit_cnt_r <= frame_last ? 6'h00 : bit_cnt_r + 6'h01;
      if (in_data) begin
        shift_r <= wdata;
      end else begin
        cmd_r <= cmd_nxt;
      end
    end
  end

  // read data is loaded after the last command bit, shifted on falls
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_r <= 24'h000000;
    end else if (spi_rise && bit_cnt_r == CMD_BITS - 6'h01) begin
      unique case (cmd_nxt[5:0])
        ADDR_RESULT: out_r <= result_r;
        ADDR_CONV_CTRL: out_r <= {conv_ctrl_r, 8'h00};
        ADDR_IO_CTRL: out_r <= {io_ctrl_r, 8'h00};
        default: out_r <= 24'h000000;
      endcase
    end else if (spi_fall && bit_cnt_r > CMD_BITS) begin
      out_r <= {out_r[22:0], 1'b0};
    end
  end

  assign rdy_on_dout = io_ctrl_r.int_route == ROUTE_DOUT ||
    (io_ctrl_r.int_route == ROUTE_INT && pkg_lfcsp);
  assign spi_sdo_oe = ~spi_cs_n;
  assign spi_sdo = (rdy_on_dout && bit_cnt_r == 6'h00) ? drdy_n_r
                                                        : out_r[23];

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      conv_ctrl_r <= amc_conv_ctrl_type'(CONV_CTRL_RST);
      io_ctrl_r <= amc_io_ctrl_type'(IO_CTRL_RST);
      mode_wr_r <= 1'b0;
    end else begin
      mode_wr_r <= 1'b0;
      if (frame_last && !cmd_read) begin
        if (cmd_r[5:0] == ADDR_CONV_CTRL) begin
          conv_ctrl_r <= amc_conv_ctrl_type'(wdata[15:0] & CONV_CTRL_WMASK);
          mode_wr_r <= 1'b1;
        end
        if (cmd_r[5:0] == ADDR_IO_CTRL) begin
          io_ctrl_r <= amc_io_ctrl_type'(wdata[15:0] & IO_CTRL_WMASK);
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // latest result and data ready
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      result_r <= RESULT_RST;
    end else if (conv_done) begin
      result_r <= conv_data;
    end
  end

  // a new result wins over the read that would release data ready
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      drdy_n_r <= 1'b1;
    end else if (conv_done) begin
      drdy_n_r <= 1'b0;
    end else if (frame_last && cmd_read && cmd_r[5:0] == ADDR_RESULT) begin
      drdy_n_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // master clock
  // ----------------------------------------------------------------------
  assign osc_half = osc_cnt_r == 10'(OSC_HALF - 1);
  assign ext_rise = clk_pin_i & ~clk_d_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      osc_cnt_r <= 10'h000;
      osc_r <= 1'b0;
    end else if (osc_half) begin
      osc_cnt_r <= 10'h000;
      osc_r <= ~osc_r;
    end else begin
      osc_cnt_r <= osc_cnt_r + 10'h001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clk_d_r <= 1'b0;
      div2_r <= 1'b0;
      mclk_tick_r <= 1'b0;
    end else begin
      clk_d_r <= clk_pin_i;
      if (ext_rise) begin
        div2_r <= ~div2_r;
      end
      unique case (conv_ctrl_r.mclk_sel)
        MCLK_INT_OFF, MCLK_INT_ON: mclk_tick_r <= osc_half & ~osc_r;
        MCLK_EXT: mclk_tick_r <= ext_rise;
        MCLK_EXT_DIV2: mclk_tick_r <= ext_rise & div2_r;
      endcase
    end
  end
  assign mclk_tick = mclk_tick_r;

  // ----------------------------------------------------------------------
  // trigger pin and fifo clear
  // ----------------------------------------------------------------------
  assign trig_fall = ~trig_n & trig_d_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      trig_d_r <= 1'b1;
      fifo_clear_r <= 1'b0;
    end else begin
      trig_d_r <= trig_n;
      fifo_clear_r <= trig_fall & io_ctrl_r.trigger_fifo_clear_enable;
    end
  end
  assign fifo_clear = fifo_clear_r;

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  assign seq_end = conv_done & conv_last;
  assign rest_len = conv_ctrl_r.duty_ratio_field ?
    ({4'h0, conv_len_r} << DUTY_SHIFT_SIXTEENTH) - {4'h0, conv_len_r} :
    ({4'h0, conv_len_r} << DUTY_SHIFT_QUARTER) - {4'h0, conv_len_r};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      seq_start_r <= 1'b0;
      rest_cnt_r <= 20'h00000;
    end else begin
      seq_start_r <= 1'b0;
      if (mode_wr_r) begin
        // reserved and lower codes leave the sequencer stopped
        state_r <= is_seq_mode(conv_ctrl_r.mode) ? ST_CONV : ST_IDLE;
        seq_start_r <= is_seq_mode(conv_ctrl_r.mode);
      end else begin
        unique case (state_r)
          ST_IDLE: state_r <= ST_IDLE;
          ST_CONV: begin
            if (trig_fall && conv_ctrl_r.mode != MODE_DUTY) begin
              seq_start_r <= 1'b1;
            end else if (seq_end && conv_ctrl_r.mode == MODE_DUTY) begin
              state_r <= ST_REST;
              rest_cnt_r <= rest_len;
            end else if (seq_end) begin
              state_r <= ST_WAIT;
            end
          end
          ST_REST: begin
            if (rest_cnt_r == 20'h00000) begin
              state_r <= ST_CONV;
              seq_start_r <= 1'b1;
            end else if (mclk_tick_r) begin
              rest_cnt_r <= rest_cnt_r - 20'h00001;
            end
          end
          ST_WAIT: begin
            if (trig_fall) begin
              state_r <= ST_CONV;
              seq_start_r <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // sequence length in master clock ticks sets the duty cycle rest
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      conv_len_r <= 16'h0000;
    end else if (seq_start_r) begin
      conv_len_r <= 16'h0000;
    end else if (state_r == ST_CONV && mclk_tick_r &&
                 conv_len_r != 16'hFFFF) begin
      conv_len_r <= conv_len_r + 16'h0001;
    end
  end

  assign seq_start = seq_start_r;
  assign seq_active = state_r == ST_CONV;
  assign standby_active = state_r == ST_REST ||
    (state_r == ST_WAIT && conv_ctrl_r.mode == MODE_SEQ_STBY);
  assign idle_active = state_r == ST_IDLE ||
    (state_r == ST_WAIT && conv_ctrl_r.mode != MODE_SEQ_STBY);

  // ----------------------------------------------------------------------
  // pin routing
  // ----------------------------------------------------------------------
  assign int_event = fifo_enable ? fifo_irq : ~drdy_n_r;
  assign pin_event = ~int_event;

  always_comb begin
    int_pin_o = 1'b1;
    int_pin_oe = 1'b0;
    if (io_ctrl_r.int_route == ROUTE_INT) begin
      if (fifo_enable) begin
        int_pin_o = ~fifo_irq;
        int_pin_oe = ~pkg_lfcsp;
      end else begin
        int_pin_o = drdy_n_r;
        int_pin_oe = ~pkg_lfcsp;
      end
    end
  end

  always_comb begin
    clk_pin_o = 1'b0;
    clk_pin_oe = 1'b0;
    if (io_ctrl_r.int_route == ROUTE_CLK) begin
      clk_pin_o = pin_event;
      clk_pin_oe = 1'b1;
    end else if (conv_ctrl_r.mclk_sel == MCLK_INT_ON) begin
      clk_pin_o = osc_r;
      clk_pin_oe = 1'b1;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_gp
    if (i == GP_TWO) begin : g_two
      assign gp_pin_o[i] = (io_ctrl_r.int_route == ROUTE_GP2) ? pin_event
                           : io_ctrl_r.gp_out_level[i];
      assign gp_pin_oe[i] = (io_ctrl_r.int_route == ROUTE_GP2) |
                            io_ctrl_r.gp_dir[i];
    end else if (i == GP_FOUR) begin : g_four
      assign gp_pin_o[i] = standby_indicator_enable ? standby_active
                           : io_ctrl_r.gp_out_level[i];
      assign gp_pin_oe[i] = standby_indicator_enable |
                            io_ctrl_r.gp_dir[i];
    end else begin : g_plain
      assign gp_pin_o[i] = io_ctrl_r.gp_out_level[i];
      assign gp_pin_oe[i] = io_ctrl_r.gp_dir[i];
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_duty_rest_entry: assert property (state_r == ST_CONV && seq_end &&
    !mode_wr_r && !trig_fall && conv_ctrl_r.mode == MODE_DUTY |=>
    standby_active && !seq_active)
    else $error("duty mode did not enter standby after sequence");

  a_seq_idle_wait: assert property (state_r == ST_CONV && seq_end &&
    !mode_wr_r && !trig_fall && conv_ctrl_r.mode == MODE_SEQ_IDLE |=>
    idle_active && !standby_active)
    else $error("single sequence idle mode did not go idle");

  a_stby_restart: assert property (state_r == ST_WAIT && trig_fall &&
    !mode_wr_r && conv_ctrl_r.mode == MODE_SEQ_STBY |=>
    seq_start && seq_active ##1 !seq_start)
    else $error("trigger fall did not restart the sequence");

  a_clk_out_int: assert property (io_ctrl_r.int_route != ROUTE_CLK |->
    clk_pin_oe == (conv_ctrl_r.mclk_sel == MCLK_INT_ON))
    else $error("clock pin drive does not follow clock select");

  a_ext_tick: assert property (conv_ctrl_r.mclk_sel == MCLK_EXT &&
    ext_rise |=> mclk_tick)
    else $error("external clock edge gave no master tick");

  a_div_tick: assert property (conv_ctrl_r.mclk_sel == MCLK_EXT_DIV2 &&
    ext_rise |=> mclk_tick == $past(div2_r))
    else $error("halved external clock tick wrong");

  a_result_latch: assert property (conv_done |=>
    result_r == $past(conv_data) && !drdy_n_r)
    else $error("result register missed the latest conversion");

  a_trig_clear: assert property (trig_fall |=>
    fifo_clear == $past(io_ctrl_r.trigger_fifo_clear_enable))
    else $error("fifo clear does not follow trigger and enable");

  a_clk_route: assert property (io_ctrl_r.int_route == ROUTE_CLK |->
    clk_pin_oe && clk_pin_o == (fifo_enable ? ~fifo_irq : drdy_n_r))
    else $error("clock pin does not carry the interrupt event");

  a_gp_two_route: assert property (io_ctrl_r.int_route == ROUTE_GP2 |->
    gp_pin_oe[GP_TWO] &&
    gp_pin_o[GP_TWO] == (fifo_enable ? ~fifo_irq : drdy_n_r))
    else $error("pin two does not carry the interrupt event");

  a_dout_ready: assert property (io_ctrl_r.int_route == ROUTE_DOUT |->
    !int_pin_oe && (spi_cs_n || bit_cnt_r != 6'h00 || spi_sdo == drdy_n_r))
    else $error("data ready not on data out pin");

  a_gp_level: assert property (io_ctrl_r.gp_dir[0] |->
    gp_pin_oe[0] && gp_pin_o[0] == io_ctrl_r.gp_out_level[0])
    else $error("output pin one does not show its level bit");

  a_standby_pin: assert property (standby_indicator_enable |->
    gp_pin_oe[GP_FOUR] && gp_pin_o[GP_FOUR] == standby_active)
    else $error("pin four does not show standby");

endmodule : amc_regs

// ---- dv/amc_host.sv ----
// amc_host: behavioural host on the four-wire serial port.
// assumes a 100 MHz ref_clk; each sclk phase lasts four cycles.
`timescale 1ns/1ps
module amc_host (
  // clock
  input wire logic ref_clk,
  // serial port
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_sdi,
  input wire logic spi_sdo
);
  initial begin
    spi_sclk = 1'b1;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
  end
  // one whole frame, length taken from the address
  task automatic xfer(input logic rd, input logic [5:0] adr,
                      input logic [23:0] wd, output logic [23:0] rdat);
    logic [31:0] sh;
    int n;
    n = (adr == 6'h02) ? 24 : (adr == 6'h01 || adr == 6'h03) ? 16 : 8;
    sh = {1'b0, rd, adr, wd << (24 - n)};
    rdat = 24'h000000;
    @(negedge ref_clk);
    spi_cs_n = 1'b0;
    for (int i = 0; i < 8 + n; i++) begin
      repeat (4) @(negedge ref_clk);
      spi_sclk = 1'b0;
      spi_sdi = sh[31-i];
      repeat (4) @(negedge ref_clk);
      spi_sclk = 1'b1;
      if (i >= 8) rdat = {rdat[22:0], spi_sdo};
    end
    repeat (4) @(negedge ref_clk);
    spi_cs_n = 1'b1;
    // released line must not keep the last bit
    spi_sdi = ~spi_sdi;
  endtask : xfer
endmodule : amc_host

// ---- dv/amc_regs_tb.sv ----
// amc_regs_tb: self-checking bench for the register bank.
// assumes the amc_host serial model and a 100 MHz ref_clk.
`timescale 1ns/1ps
module amc_regs_tb import amc_pkg::*;;
  logic ref_clk, rst, spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
  logic conv_done, conv_last, seq_start, seq_active, standby_active;
  logic idle_active, mclk_tick, fifo_enable, fifo_irq, fifo_clear;
  logic trig_n, standby_indicator_enable, int_pin_o, int_pin_oe, pkg_lfcsp;
  logic clk_pin_i, clk_pin_o, clk_pin_oe;
  logic [3:0] gp_pin_o, gp_pin_oe;
  logic [7:0] v;
  logic [23:0] conv_data, rd_val, d;
  logic [23:0] exp_q[$];
  logic [3:0] modes[3] = '{MODE_DUTY, MODE_SEQ_IDLE, MODE_SEQ_STBY};
  int bad_count, checks_done, starts, clears, ticks, cyc, s0;
  event rd_ev;

  amc_regs #(.OSC_HALF(4)) amc_regs_i (.ref_clk, .rst, .spi_sclk,
    .spi_cs_n, .spi_sdi, .spi_sdo, .spi_sdo_oe, .conv_done, .conv_last,
    .conv_data, .seq_start, .seq_active, .standby_active, .idle_active,
    .mclk_tick, .fifo_enable, .fifo_irq, .fifo_clear, .trig_n,
    .pkg_lfcsp, .standby_indicator_enable, .int_pin_o, .int_pin_oe,
    .clk_pin_i, .clk_pin_o, .clk_pin_oe, .gp_pin_o, .gp_pin_oe);
  amc_host amc_host_i (.ref_clk, .spi_sclk, .spi_cs_n, .spi_sdi,
    .spi_sdo);

  // ------------------------------------------------------------
  // clock, pulse counters, checking
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    starts += seq_start;
    clears += fifo_clear;
    ticks += mclk_tick;
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  always @(rd_ev) chk("read", exp_q.pop_front(), rd_val);
  task automatic rd(logic [5:0] a, logic [23:0] e);
    exp_q.push_back(e);
    amc_host_i.xfer(1'b1, a, 24'h000000, rd_val);
    ->rd_ev;
  endtask : rd
  task automatic wr(logic [5:0] a, logic [23:0] w);
    logic [23:0] unused;
    amc_host_i.xfer(1'b0, a, w, unused);
  endtask : wr
  task automatic conv(logic [23:0] w, logic last);
    @(negedge ref_clk);
    conv_done = 1'b1;
    conv_data = w;
    conv_last = last;
    @(negedge ref_clk);
    conv_done = 1'b0;
    conv_data = ~w;
    repeat (2) @(negedge ref_clk);
  endtask : conv
  task automatic trig();
    trig_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    trig_n = 1'b1;
    repeat (4) @(negedge ref_clk);
  endtask : trig
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    {conv_done, conv_last, fifo_enable, fifo_irq} = 4'h0;
    {standby_indicator_enable, clk_pin_i, pkg_lfcsp} = 3'h0;
    rst = 1'b1;
    trig_n = 1'b1;
    conv_data = 24'h000000;
    void'($urandom(17861));
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    rd(ADDR_CONV_CTRL, {8'h00, CONV_CTRL_RST});
    rd(ADDR_RESULT, RESULT_RST);
    rd(ADDR_IO_CTRL, {8'h00, IO_CTRL_RST});
    rd(6'h05, 24'h000000);
    foreach (modes[i]) begin
      s0 = starts;
      wr(ADDR_CONV_CTRL, {18'h0, modes[i], MCLK_INT_OFF});
      chk("seq_start", 1, starts - s0);
      repeat (100) @(negedge ref_clk);
      d = $urandom;
      conv(d, 1'b1);
      chk("stby", modes[i] != MODE_SEQ_IDLE, standby_active);
      chk("idle", modes[i] == MODE_SEQ_IDLE, idle_active);
      s0 = starts;
      rd(ADDR_RESULT, d);
      if (modes[i] != MODE_DUTY) trig();
      repeat (400) @(negedge ref_clk);
      chk("restart", 1, starts - s0);
      chk("active", 1, seq_active);
    end
    // ratio 1/16: rest is fifteen times the conversion time
    wr(ADDR_CONV_CTRL, {17'h0, 1'b1, MODE_DUTY, MCLK_INT_OFF});
    repeat (24) @(negedge ref_clk);
    conv(d, 1'b1);
    s0 = starts;
    repeat (300) @(negedge ref_clk);
    chk("ratio_rest", 0, starts - s0);
    repeat (250) @(negedge ref_clk);
    chk("ratio_end", 1, starts - s0);
    wr(ADDR_RESULT, ~d);
    rd(ADDR_RESULT, d);
    wr(ADDR_CONV_CTRL, 24'h000000);
    for (int e = 0; e < 2; e++) begin
      wr(ADDR_IO_CTRL, 24'(e) << 10);
      s0 = clears;
      trig();
      chk("fifo_clear", e, clears - s0);
    end
    repeat (3) begin
      v = $urandom;
      wr(ADDR_IO_CTRL, {16'h0000, v});
      chk("gp_oe", v[3:0], gp_pin_oe);
      chk("gp_o", v[7:4] & v[3:0], gp_pin_o & v[3:0]);
    end
    standby_indicator_enable = 1'b1;
    wr(ADDR_IO_CTRL, 24'h000099);
    chk("p4", 2'b10, {gp_pin_oe[GP_FOUR], gp_pin_o[GP_FOUR]});
    standby_indicator_enable = 1'b0;
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_IO_CTRL, 24'(r) << 8);
      d = $urandom;
      conv(d, 1'b0);
      case (r)
        0: chk("int", 2'b10, {int_pin_oe, int_pin_o});
        1: chk("clk", 2'b10, {clk_pin_oe, clk_pin_o});
        2: chk("p2", 2'b10, {gp_pin_oe[GP_TWO], gp_pin_o[GP_TWO]});
        default: chk("dout", 0, {int_pin_oe, spi_sdo, spi_sdo_oe});
      endcase
      rd(ADDR_RESULT, d);
    end
    pkg_lfcsp = 1'b1;
    wr(ADDR_IO_CTRL, 24'h000000);
    conv(d, 1'b0);
    chk("lfcsp", 0, {int_pin_oe, spi_sdo, spi_sdo_oe});
    rd(ADDR_RESULT, d);
    pkg_lfcsp = 1'b0;
    wr(ADDR_IO_CTRL, 24'h000000);
    {fifo_enable, fifo_irq} = 2'b11;
    repeat (2) @(negedge ref_clk);
    chk("fifo_int", 0, int_pin_o);
    fifo_irq = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("fifo_int", 1, int_pin_o);
    fifo_enable = 1'b0;
    wr(ADDR_CONV_CTRL, {22'h0, MCLK_INT_OFF});
    chk("clk_oe", 0, clk_pin_oe);
    s0 = ticks;
    repeat (80) @(negedge ref_clk);
    chk("osc", 10, ticks - s0);
    wr(ADDR_CONV_CTRL, {22'h0, MCLK_INT_ON});
    chk("clk_oe", 1, clk_pin_oe);
    for (int c = 2; c < 4; c++) begin
      wr(ADDR_CONV_CTRL, 24'(c));
      s0 = ticks;
      repeat (16) begin
        repeat (8) @(negedge ref_clk);
        clk_pin_i = ~clk_pin_i;
      end
      repeat (8) @(negedge ref_clk);
      chk("ext", c == 2 ? 8 : 4, ticks - s0);
    end
    report_and_stop();
  end
endmodule : amc_regs_tb
